// File: hw/pam_pkg.sv
package pam_pkg;

  // ----------------------------------------------------------------
  // Register addresses in the core's special function space
  // ----------------------------------------------------------------
  localparam logic [7:0] PAM_ADR_P1_SEL_LO = 8'h8E;
  localparam logic [7:0] PAM_ADR_P1_SEL_HI = 8'h8F;
  localparam logic [7:0] PAM_ADR_P3_SEL    = 8'h91;
  localparam logic [7:0] PAM_ADR_P4_SEL_LO = 8'h92;
  localparam logic [7:0] PAM_ADR_P4_SEL_HI = 8'h93;
  localparam logic [7:0] PAM_ADR_P1_LATCH  = 8'h90;
  localparam logic [7:0] PAM_ADR_P3_LATCH  = 8'hB0;
  localparam logic [7:0] PAM_ADR_P4_LATCH  = 8'hC0;

  // ----------------------------------------------------------------
  // Reset values and pin layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  PAM_SEL_RST   = 8'h00;
  localparam logic [7:0]  PAM_LATCH_RST = 8'hFF;
  localparam logic [7:0]  PAM_RDATA_RST = 8'h00;
  localparam logic [23:0] PAM_PREV_RST  = 24'hFFFFFF;
  localparam int          PAM_PINS      = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PAM_GPIO, PAM_QUASI, PAM_INPUT, PAM_ANALOG, PAM_OPEN, PAM_PUSH
  } pam_drive_t;

  typedef struct packed {
    pam_drive_t mode;
    logic       data;
  } pam_pin_t;

  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull;
  } pam_pad1_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pam_sfr_req_t;

  typedef struct packed {
    logic       serial0_transmit;
    logic       serial1_transmit;
    logic       spi_clock_pin;
    logic       spi_transmit_pin;
    logic       spi_select_pin;
    logic       i2c_data_pin;
    logic       i2c_clock_pin;
    logic [5:0] counter_module;
  } pam_periph_out_t;

  typedef struct packed {
    logic       serial0_receive;
    logic       external_interrupt_0;
    logic       external_interrupt_1;
    logic       counter0_input;
    logic       counter1_input;
    logic       i2c_data_pin;
    logic       i2c_clock_pin;
    logic       timer2_count_input;
    logic       timer2_trigger_input;
    logic       serial1_receive;
    logic       spi_clock_pin;
    logic       spi_receive_pin;
    logic       spi_select_pin;
    logic [5:0] counter_module;
    logic       counter_array0_ext_clock;
    logic       counter_array1_ext_clock;
  } pam_periph_in_t;

endpackage

// File: hw/pam_mux.sv
`timescale 1ns/1ps
// What this block does
// RULE1 - Reset clears all five select registers so every pin is GPIO.
// RULE2 - Each pin's function is chosen on its own select bits only.
// RULE3 - Timer 2 and serial 1 may sit on Port 1 or Port 4 independently.
// RULE4 - Serial and SPI pins are quasi with a one-cycle strong high pulse.
// RULE5 - Timer and counter-array input pins are quasi and input only.
// RULE6 - Analog pins have pull-up and output driver both off, routed to the ADC.
// RULE7 - Only Port 1 pins can be routed to the analog converter.
// RULE8 - I2C pins are open drain with no strong high pulse.
// RULE9 - Only Port 3 offers open drain, so only it carries I2C.
// RULE10 - Counter-array outputs are push-pull, available on Port 4 only.
// RULE11 - Port 3 has one select bit per pin with a fixed function order.
// RULE12 - Port 1 decodes two bits: I/O, first alternate, second alternate.
// RULE13 - Port 1 alternates are timer 2, serial 1, SPI, then ADC channels.
// RULE14 - Port 4 decodes its two select bits the same way as Port 1.
// RULE15 - Port 4 alternates are counter array, then timer 2/serial 1/SPI.
// RULE16 - Reset sets the three port output latches to all ones.
// RULE17 - A peripheral input selected on both ports is fed from Port 1.
module pam_mux
  import pam_pkg::*;
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // Special function register access
  input  wire pam_pkg::pam_sfr_req_t    sfr_req,
  output logic [7:0]                    sfr_rdata,
  // Peripheral side
  input  wire pam_pkg::pam_periph_out_t periph_out,
  output pam_pkg::pam_periph_in_t       periph_in,
  // Pads: port 1 in [7:0], port 3 in [15:8], port 4 in [23:16]
  input  wire logic [23:0]              pad_in,
  output logic [23:0]                   pad_out,
  output logic [23:0]                   pad_oe_n,
  output logic [23:0]                   pad_pull_en,
  output logic [7:0]                    pad_analog_en
);
  import pam_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]     sel1_lo;
    logic [7:0]     sel1_hi;
    logic [7:0]     sel3;
    logic [7:0]     sel4_lo;
    logic [7:0]     sel4_hi;
    logic [7:0]     lat1;
    logic [7:0]     lat3;
    logic [7:0]     lat4;
    logic [23:0]    s1;
    logic [23:0]    s2;
    logic [23:0]    prev;
    logic [23:0]    out;
    logic [23:0]    oe_n;
    logic [23:0]    pull;
    logic [7:0]     ana;
    logic [7:0]     rdata;
    pam_periph_in_t pin;
  } pam_state_t;

  pam_state_t q_r;
  pam_state_t q_nxt;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Timer 2 / serial 1 / SPI group, shared by Port 1 and Port 4
  function automatic pam_pin_t spi_side(input int k,
                                        input pam_periph_out_t po);
    pam_pin_t r;
    r = '{mode: PAM_QUASI, data: 1'b1};
    unique case (k)
      0, 1: r.mode = PAM_INPUT;                      // [RULE5]
      3: r.data = po.serial1_transmit;               // [RULE4]
      4: r.data = po.spi_clock_pin;
      6: r.data = po.spi_transmit_pin;
      7: r.data = po.spi_select_pin;
      default: r.data = 1'b1;
    endcase
    return r;
  endfunction

  // Pad drive for a mode; prev is the data seen one cycle earlier
  function automatic pam_pad1_t drive(input pam_drive_t m,
                                      input logic d,
                                      input logic prev);
    pam_pad1_t p;
    p = '{out: 1'b1, oe_n: 1'b1, pull: 1'b1};
    unique case (m)
      PAM_GPIO, PAM_QUASI: begin
        if (!d) begin
          p = '{out: 1'b0, oe_n: 1'b0, pull: 1'b0};
        end else if (!prev) begin
          p.oe_n = 1'b0;                             // [RULE4]
        end
      end
      PAM_INPUT: p = '{out: 1'b1, oe_n: 1'b1, pull: 1'b1};
      PAM_ANALOG: p = '{out: 1'b0, oe_n: 1'b1, pull: 1'b0}; // [RULE6]
      PAM_OPEN: begin
        if (!d) begin                                // [RULE8]
          p = '{out: 1'b0, oe_n: 1'b0, pull: 1'b0};
        end
      end
      PAM_PUSH: p = '{out: d, oe_n: 1'b0, pull: 1'b0}; // [RULE10]
      default: p = '{out: 1'b1, oe_n: 1'b1, pull: 1'b1};
    endcase
    return p;
  endfunction

  // Port 1 wins when both ports carry the same input
  function automatic logic pick(input logic hit1, input logic v1,
                                input logic hit4, input logic v4);
    return hit1 ? v1 : (hit4 ? v4 : 1'b1);           // [RULE17]
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  pam_pin_t   fn  [PAM_PINS];
  pam_pad1_t  pd;
  logic [7:0] p1a1, p4a1, p4a2;
  logic [7:0] pn1, pn3, pn4;

  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = pad_in;
    q_nxt.s2 = q_r.s1;
    pn1 = q_r.s2[7:0];
    pn3 = q_r.s2[15:8];
    pn4 = q_r.s2[23:16];
    // Register writes
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        PAM_ADR_P1_SEL_LO: q_nxt.sel1_lo = sfr_req.wdata;
        PAM_ADR_P1_SEL_HI: q_nxt.sel1_hi = sfr_req.wdata;
        PAM_ADR_P3_SEL:    q_nxt.sel3    = sfr_req.wdata;
        PAM_ADR_P4_SEL_LO: q_nxt.sel4_lo = sfr_req.wdata;
        PAM_ADR_P4_SEL_HI: q_nxt.sel4_hi = sfr_req.wdata;
        PAM_ADR_P1_LATCH:  q_nxt.lat1    = sfr_req.wdata;
        PAM_ADR_P3_LATCH:  q_nxt.lat3    = sfr_req.wdata;
        PAM_ADR_P4_LATCH:  q_nxt.lat4    = sfr_req.wdata;
        default: ;
      endcase
    end
    // Port reads return the pin levels, not the latches
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        PAM_ADR_P1_SEL_LO: q_nxt.rdata = q_r.sel1_lo;
        PAM_ADR_P1_SEL_HI: q_nxt.rdata = q_r.sel1_hi;
        PAM_ADR_P3_SEL:    q_nxt.rdata = q_r.sel3;
        PAM_ADR_P4_SEL_LO: q_nxt.rdata = q_r.sel4_lo;
        PAM_ADR_P4_SEL_HI: q_nxt.rdata = q_r.sel4_hi;
        PAM_ADR_P1_LATCH:  q_nxt.rdata = pn1;
        PAM_ADR_P3_LATCH:  q_nxt.rdata = pn3;
        PAM_ADR_P4_LATCH:  q_nxt.rdata = pn4;
        default:           q_nxt.rdata = 8'h00;
      endcase
    end
    // Per-pin function decode, each pin on its own bits  [RULE2]
    p1a1 = q_r.sel1_lo & ~q_r.sel1_hi;                // [RULE12]
    p4a1 = q_r.sel4_lo & ~q_r.sel4_hi;                // [RULE14]
    p4a2 = q_r.sel4_lo & q_r.sel4_hi;
    for (int i = 0; i < 8; i++) begin
      // Port 1
      if (!q_r.sel1_lo[i]) begin
        fn[i] = '{mode: PAM_GPIO, data: q_r.lat1[i]};
      end else if (!q_r.sel1_hi[i]) begin
        fn[i] = spi_side(i, periph_out);              // [RULE13]
      end else begin
        fn[i] = '{mode: PAM_ANALOG, data: 1'b1};      // [RULE7]
      end
      // Port 3
      if (!q_r.sel3[i]) begin
        fn[8+i] = '{mode: PAM_GPIO, data: q_r.lat3[i]};
      end else begin
        unique case (i)                               // [RULE11]
          0: fn[8+i] = '{mode: PAM_QUASI, data: 1'b1};
          1: fn[8+i] = '{mode: PAM_QUASI,
                         data: periph_out.serial0_transmit};
          6: fn[8+i] = '{mode: PAM_OPEN,              // [RULE9]
                         data: periph_out.i2c_data_pin};
          7: fn[8+i] = '{mode: PAM_OPEN,
                         data: periph_out.i2c_clock_pin};
          default: fn[8+i] = '{mode: PAM_INPUT, data: 1'b1};
        endcase
      end
      // Port 4
      if (!q_r.sel4_lo[i]) begin
        fn[16+i] = '{mode: PAM_GPIO, data: q_r.lat4[i]};
      end else if (!q_r.sel4_hi[i]) begin
        unique case (i)                               // [RULE15]
          3, 7: fn[16+i] = '{mode: PAM_INPUT, data: 1'b1};
          0, 1, 2: fn[16+i] = '{mode: PAM_PUSH,
                     data: periph_out.counter_module[i]};
          default: fn[16+i] = '{mode: PAM_PUSH,
                     data: periph_out.counter_module[i-1]};
        endcase
      end else begin
        fn[16+i] = spi_side(i, periph_out);           // [RULE15]
      end
    end
    for (int j = 0; j < PAM_PINS; j++) begin
      pd = drive(fn[j].mode, fn[j].data, q_r.prev[j]);
      q_nxt.out[j]  = pd.out;
      q_nxt.oe_n[j] = pd.oe_n;
      q_nxt.pull[j] = pd.pull;
      q_nxt.prev[j] = fn[j].data;
    end
    for (int a = 0; a < 8; a++) begin
      q_nxt.ana[a] = fn[a].mode == PAM_ANALOG;       // [RULE6]
    end
    // Peripheral inputs; unselected inputs idle high
    q_nxt.pin.serial0_receive      = q_r.sel3[0] ? pn3[0] : 1'b1;
    q_nxt.pin.external_interrupt_0 = q_r.sel3[2] ? pn3[2] : 1'b1;
    q_nxt.pin.external_interrupt_1 = q_r.sel3[3] ? pn3[3] : 1'b1;
    q_nxt.pin.counter0_input       = q_r.sel3[4] ? pn3[4] : 1'b1;
    q_nxt.pin.counter1_input       = q_r.sel3[5] ? pn3[5] : 1'b1;
    q_nxt.pin.i2c_data_pin         = q_r.sel3[6] ? pn3[6] : 1'b1;
    q_nxt.pin.i2c_clock_pin        = q_r.sel3[7] ? pn3[7] : 1'b1;
    q_nxt.pin.timer2_count_input   =                 // [RULE3]
      pick(p1a1[0], pn1[0], p4a2[0], pn4[0]);
    q_nxt.pin.timer2_trigger_input =
      pick(p1a1[1], pn1[1], p4a2[1], pn4[1]);
    q_nxt.pin.serial1_receive      =
      pick(p1a1[2], pn1[2], p4a2[2], pn4[2]);
    q_nxt.pin.spi_clock_pin        =
      pick(p1a1[4], pn1[4], p4a2[4], pn4[4]);
    q_nxt.pin.spi_receive_pin      =
      pick(p1a1[5], pn1[5], p4a2[5], pn4[5]);
    q_nxt.pin.spi_select_pin       =
      pick(p1a1[7], pn1[7], p4a2[7], pn4[7]);
    q_nxt.pin.counter_module = {p4a1[6:4], p4a1[2:0]} &
                               {pn4[6:4], pn4[2:0]} |
                               ~{p4a1[6:4], p4a1[2:0]};
    q_nxt.pin.counter_array0_ext_clock = p4a1[3] ? pn4[3] : 1'b1;
    q_nxt.pin.counter_array1_ext_clock = p4a1[7] ? pn4[7] : 1'b1;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r         <= '0;
      q_r.sel1_lo <= PAM_SEL_RST;                     // [RULE1]
      q_r.sel1_hi <= PAM_SEL_RST;
      q_r.sel3    <= PAM_SEL_RST;
      q_r.sel4_lo <= PAM_SEL_RST;
      q_r.sel4_hi <= PAM_SEL_RST;
      q_r.lat1    <= PAM_LATCH_RST;                   // [RULE16]
      q_r.lat3    <= PAM_LATCH_RST;
      q_r.lat4    <= PAM_LATCH_RST;
      q_r.prev    <= PAM_PREV_RST;
      q_r.oe_n    <= PAM_PREV_RST;
      q_r.out     <= PAM_PREV_RST;
      q_r.pull    <= PAM_PREV_RST;
      q_r.rdata   <= PAM_RDATA_RST;
      q_r.pin     <= '1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sfr_rdata     = q_r.rdata;
  assign periph_in     = q_r.pin;
  assign pad_out       = q_r.out;
  assign pad_oe_n      = q_r.oe_n;
  assign pad_pull_en   = q_r.pull;
  assign pad_analog_en = q_r.ana;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  reset_clear_a: assert property ($rose(rst_n) |->  // [RULE1]
    (q_r.sel1_lo | q_r.sel1_hi | q_r.sel3 |
     q_r.sel4_lo | q_r.sel4_hi) == 8'h00)
    else $error("select registers not clear after reset");

  reset_latch_a: assert property ($rose(rst_n) |->  // [RULE16]
    (q_r.lat1 & q_r.lat3 & q_r.lat4) == 8'hFF)
    else $error("port latches not all ones after reset");

  high_pulse_a: assert property (                   // [RULE4]
    (!pad_oe_n[9] && pad_out[9]) |=> (pad_oe_n[9] || !pad_out[9]))
    else $error("strong high driver held past one cycle");

  open_drain_a: assert property (                   // [RULE8]
    $past(q_r.sel3[6]) |-> !(!pad_oe_n[14] && pad_out[14]))
    else $error("open-drain pin driven high");

  analog_off_a: assert property (                   // [RULE6]
    $past(q_r.sel1_lo[0] && q_r.sel1_hi[0]) |->
      (pad_oe_n[0] && !pad_pull_en[0] && pad_analog_en[0]))
    else $error("analog pin not released");

  push_pull_a: assert property (                    // [RULE10]
    $past(p4a1[0]) |->
      (!pad_oe_n[16] && pad_out[16] == $past(periph_out.counter_module[0])))
    else $error("counter output not push-pull");

  p3_transmit_a: assert property (                  // [RULE11]
    $past(q_r.sel3[1] && !periph_out.serial0_transmit) |->
      (!pad_oe_n[9] && !pad_out[9]))
    else $error("serial 0 transmit low not driven");

  input_only_a: assert property (                   // [RULE5]
    $past(q_r.sel3[4]) |-> (pad_oe_n[12] && pad_pull_en[12]))
    else $error("counter input pin driven");

  gpio_low_a: assert property (                     // [RULE12]
    $past(!q_r.sel1_lo[2] && !q_r.lat1[2]) |->
      (!pad_oe_n[2] && !pad_out[2]))
    else $error("GPIO low not driven");

  port1_wins_a: assert property (                   // [RULE17]
    $past(p1a1[0] && p4a2[0]) |->
      periph_in.timer2_count_input == $past(q_r.s2[0]))
    else $error("timer 2 count not taken from port 1");

  split_cov: cover property (p1a1[2] ##1 p4a2[0]);
  i2c_cov:   cover property (q_r.sel3[7:6] == 2'b11 ##1 !pad_oe_n[14]);
  adc_cov:   cover property (pad_analog_en != 8'h00);
  pulse_cov: cover property (!pad_oe_n[9] && pad_out[9]);

endmodule

// File: bench/pam_pads.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Board and pad model: settles each pad from the mux drive,
// an external driver and the weak pull-ups
// ------------------------------------------------------------
module pam_pads (
  // Clock
  input  wire logic        sys_clk,
  // From the mux
  input  wire logic [23:0] pad_out,
  input  wire logic [23:0] pad_oe_n,
  input  wire logic [23:0] pad_pull_en,
  // External drivers on the board
  input  wire logic [23:0] ext_en,
  input  wire logic [23:0] ext_val,
  // Settled pad levels
  output logic [23:0]      pad_in
);
  logic [23:0] float_r = 24'h000000;

  // A floating pad toggles so that no stale level can be read back
  always @(posedge sys_clk) begin
    float_r <= ~float_r;
  end

  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (!pad_oe_n[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pull_en[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = float_r[i];
      end
    end
  end
endmodule

// File: bench/pam_mux_tb.sv
`timescale 1ns/1ps
module pam_mux_tb;
  import pam_pkg::*;
  logic            sys_clk;
  logic            rst_n;
  pam_sfr_req_t    req;
  logic [7:0]      rdata;
  pam_periph_out_t po;
  pam_periph_in_t  pi;
  logic [23:0]     pin;
  logic [23:0]     pout;
  logic [23:0]     poe_n;
  logic [23:0]     ppull;
  logic [7:0]      pana;
  logic [23:0]     ext_en;
  logic [23:0]     ext_val;
  int              err_count;
  int              samples_checked;
  logic [7:0]      adr [5] = '{8'h8E, 8'h8F, 8'h91, 8'h92, 8'h93};
  logic [7:0]      pat [5] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'h96};

  pam_mux dut (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_req(req),
    .sfr_rdata(rdata), .periph_out(po), .periph_in(pi), .pad_in(pin),
    .pad_out(pout), .pad_oe_n(poe_n), .pad_pull_en(ppull),
    .pad_analog_en(pana));

  pam_pads pads (.sys_clk(sys_clk), .pad_out(pout), .pad_oe_n(poe_n),
    .pad_pull_en(ppull), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pin));

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // Bus and check tasks, all entered at a falling edge
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Strobe is dropped, then one edge passes, so calls chain safely
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge sys_clk);
    req.wr = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge sys_clk);
    req.rd = 1'b0;
    @(negedge sys_clk);
    chk("read data", 24'(exp), 24'(rdata));
  endtask

  task automatic end_sim;
    $display("Checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Watchdog: the tests need about 125 cycles, this allows 10000
  // ------------------------------------------------------------
  initial begin
    #100us;
    err_count++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    po = '1;
    ext_en = 24'h000000;
    ext_val = 24'h000000;
    err_count = 0;
    samples_checked = 0;
    wait_n(4);
    rst_n = 1'b1;
    wait_n(3);
    chk("oe_n after reset", 24'hFFFFFF, poe_n);
    chk("pull after reset", 24'hFFFFFF, ppull);
    chk("analog after reset", 24'h0, 24'(pana));
    for (int i = 0; i < 5; i++) rd(adr[i], 8'h00);
    rd(8'h90, 8'hFF);
    rd(8'hB0, 8'hFF);
    rd(8'hC0, 8'hFF);
    for (int i = 0; i < 5; i++) wr(adr[i], pat[i]);
    for (int i = 0; i < 5; i++) rd(adr[i], pat[i]);
    rd(8'h94, 8'h00);
    for (int i = 0; i < 5; i++) wr(adr[i], 8'h00);
    // GPIO latch low drives the pin; the port read returns the pin
    wr(8'h90, 8'hFB);
    wait_n(2);
    chk("p1.2 low", 24'h0, 24'({poe_n[2], pout[2]}));
    rd(8'h90, 8'hFB);
    wr(8'h90, 8'hFF);
    // Serial 0 transmit: low is driven, rise gets one strong cycle
    po.serial0_transmit = 1'b0;
    wr(8'h91, 8'h03);
    wait_n(3);
    chk("p3.1 low", 24'h0, 24'({poe_n[9], pout[9]}));
    po.serial0_transmit = 1'b1;
    @(negedge sys_clk);
    chk("p3.1 strong", 24'h1, 24'({poe_n[9], pout[9]}));
    @(negedge sys_clk);
    chk("p3.1 weak", 24'h3, 24'({poe_n[9], ppull[9]}));
    ext_en[8] = 1'b1;
    wait_n(4);
    chk("serial0 receive", 24'h0, 24'(pi.serial0_receive));
    ext_en[8] = 1'b0;
    // I2C data open drain, counter 0 input only
    po.i2c_data_pin = 1'b0;
    wr(8'h91, 8'hD0);
    ext_en[12] = 1'b1;
    wait_n(4);
    chk("i2c low", 24'h0, 24'(poe_n[14]));
    chk("counter0 in", 24'h0, 24'(pi.counter0_input));
    chk("counter0 pad", 24'h1, 24'(poe_n[12]));
    po.i2c_data_pin = 1'b1;
    @(negedge sys_clk);
    chk("i2c no pulse", 24'h1, 24'(poe_n[14]));
    @(negedge sys_clk);
    chk("i2c released", 24'h3, 24'({poe_n[14], ppull[14]}));
    ext_en[12] = 1'b0;
    // Port 1 two-bit decode
    wr(8'h8F, 8'h01);
    wait_n(3);
    chk("p1 hi only", 24'h3, 24'({pana[0], poe_n[0], ppull[0]}));
    wr(8'h8E, 8'h01);
    wait_n(3);
    chk("p1 analog", 24'h6, 24'({pana[0], poe_n[0], ppull[0]}));
    chk("analog mask", 24'h01, 24'(pana));
    wr(8'h8F, 8'h00);
    ext_en[0] = 1'b1;
    wait_n(4);
    chk("t2 from p1", 24'h0, 24'(pi.timer2_count_input));
    chk("t2 pad", 24'h1, 24'(poe_n[0]));
    // Port 4 second alternates; Port 1 keeps priority
    wr(8'h92, 8'hFF);
    wr(8'h93, 8'hFF);
    ext_en[16] = 1'b1;
    ext_val[16] = 1'b1;
    wait_n(4);
    chk("no p4 analog", 24'h0, 24'(pana));
    chk("p4 pulls kept", 24'hFF, 24'(ppull[23:16]));
    chk("p1 wins", 24'h0, 24'(pi.timer2_count_input));
    wr(8'h8E, 8'h00);
    ext_val[16] = 1'b0;
    wait_n(4);
    chk("t2 from p4", 24'h0, 24'(pi.timer2_count_input));
    // Port 4 first alternates: counter modules push-pull
    ext_en = 24'h080000;
    ext_val = 24'h000000;
    po.counter_module = 6'h00;
    wr(8'h93, 8'h00);
    wait_n(4);
    chk("p4 oe_n", 24'h88, 24'(poe_n[23:16]));
    chk("p4 low", 24'h00, 24'(pout[23:16] & 8'h77));
    chk("ext clock", 24'h0, 24'(pi.counter_array0_ext_clock));
    po.counter_module = 6'h29;
    wait_n(5);
    chk("p4 mixed out", 24'h51, 24'(pout[23:16] & 8'h77));
    chk("counter pins in", 24'h29, 24'(pi.counter_module));
    chk("p4 high held", 24'h88, 24'(poe_n[23:16]));
    end_sim();
  end
endmodule
